// ---- rtl/cie_pkg.sv ----
// Shared constants and types for the instruction execution block
package cie_pkg;
   // Operation selector, already decoded from the opcode by the fetch stage
   typedef enum logic [4:0] {
      OP_ADD      = 5'b00000, OP_AND      = 5'b00001, OP_CP       = 5'b00010,
      OP_SUB      = 5'b00011, OP_CLR      = 5'b00100, OP_DEC      = 5'b00101,
      OP_INC      = 5'b00110, OP_COM      = 5'b00111, OP_RLC      = 5'b01000,
      OP_SLA      = 5'b01001, OP_BR_C     = 5'b01010, OP_BR_NC    = 5'b01011,
      OP_BR_Z     = 5'b01100, OP_BR_NZ    = 5'b01101, OP_BR_BCLR  = 5'b01110,
      OP_BR_BSET  = 5'b01111, OP_BSET     = 5'b10000, OP_BCLR     = 5'b10001,
      OP_NOP      = 5'b10010, OP_RET      = 5'b10011, OP_RETURN_FROM_INTERRUPT     = 5'b10100,
      OP_STOP     = 5'b10101, OP_WAIT     = 5'b10110, OP_JP       = 5'b10111,
      OP_CALL     = 5'b11000
   } cie_op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } cie_state_t;

   // Cycle counts per instruction group
   localparam logic [2:0] CYC_ALU    = 3'h4;
   localparam logic [2:0] CYC_BR     = 3'h2;
   localparam logic [2:0] CYC_BIT_BR = 3'h5;
   localparam logic [2:0] CYC_BIT    = 3'h4;
   localparam logic [2:0] CYC_CTRL   = 3'h2;
   localparam logic [2:0] CYC_JP     = 3'h4;
   // Instruction lengths in bytes
   localparam logic [1:0] LEN_BR     = 2'h1;
   localparam logic [1:0] LEN_BIT_BR = 2'h3;
   localparam logic [1:0] LEN_BIT    = 2'h2;
   localparam logic [1:0] LEN_CTRL   = 2'h1;
   localparam logic [1:0] LEN_JP     = 2'h2;
   // Base added to the pc before the signed displacement
   localparam logic [11:0] REL5_BASE = 12'h001;
   localparam logic [11:0] REL8_BASE = 12'h002;
   localparam int          PC_W      = 12;
   localparam int          DATA_W    = 8;
   localparam logic [11:0] PC_RESET  = 12'h000;
   localparam logic [7:0]  ACC_RESET = 8'h00;
endpackage

// ---- rtl/cie_alu_if.sv ----
// Signals between the sequencer and the arithmetic unit
`timescale 1ns/1ps
interface cie_alu_if;
   cie_pkg::cie_op_t op;
   logic [7:0]       opA;
   logic [7:0]       opB;
   logic [2:0]       bitIdx;
   logic             zIn;
   logic             cIn;
   logic             dstAcc;
   logic [7:0]       res;
   logic             zOut;
   logic             cOut;
   logic             updZ;
   logic             updC;
   logic             take;

   modport seq (output op, opA, opB, bitIdx, zIn, cIn, dstAcc,
                input  res, zOut, cOut, updZ, updC, take);
   modport alu (input  op, opA, opB, bitIdx, zIn, cIn, dstAcc,
                output res, zOut, cOut, updZ, updC, take);
endinterface

// ---- rtl/cie_alu.sv ----
// Result, flag and branch-condition logic for one instruction
`timescale 1ns/1ps
module cie_alu (
   // Operands and results
   cie_alu_if.alu a
);
   logic [8:0] wide;

   // Result and flag effects by operation
   always_comb begin
      wide    = 9'h000;
      a.res   = a.opA;
      a.updZ  = 1'b0;
      a.updC  = 1'b0;
      a.cOut  = a.cIn;
      a.take  = 1'b0;
      case (a.op)
         cie_pkg::OP_ADD: begin
            wide   = {1'b0, a.opA} + {1'b0, a.opB};
            a.res  = wide[7:0];
            a.cOut = wide[8];
            a.updZ = 1'b1;
            a.updC = 1'b1;
         end
         cie_pkg::OP_AND: begin
            a.res  = a.opA & a.opB;
            a.cOut = 1'b0;
            a.updZ = 1'b1;
            a.updC = 1'b1;
         end
         // Compare and subtract report a borrow in carry
         cie_pkg::OP_CP, cie_pkg::OP_SUB: begin
            wide   = {1'b0, a.opA} - {1'b0, a.opB};
            a.res  = wide[7:0];
            a.cOut = wide[8];
            a.updZ = 1'b1;
            a.updC = 1'b1;
         end
         // clear of a register keeps flags
         cie_pkg::OP_CLR: begin
            a.res  = 8'h00;
            a.cOut = 1'b0;
            a.updZ = a.dstAcc;
            a.updC = a.dstAcc;
         end
         cie_pkg::OP_DEC: begin
            a.res  = a.opA - 8'h01;
            a.updZ = 1'b1;
         end
         cie_pkg::OP_INC: begin
            a.res  = a.opA + 8'h01;
            a.updZ = 1'b1;
         end
         cie_pkg::OP_COM: begin
            a.res  = ~a.opA;
            a.cOut = a.opA[7];
            a.updZ = 1'b1;
            a.updC = 1'b1;
         end
         // msb to carry, old carry in
         cie_pkg::OP_RLC: begin
            a.res  = {a.opA[6:0], a.cIn};
            a.cOut = a.opA[7];
            a.updZ = 1'b1;
            a.updC = 1'b1;
         end
         cie_pkg::OP_SLA: begin
            a.res  = {a.opA[6:0], 1'b0};
            a.cOut = a.opA[7];
            a.updZ = 1'b1;
            a.updC = 1'b1;
         end
         cie_pkg::OP_BR_C:  a.take = a.cIn;
         cie_pkg::OP_BR_NC: a.take = ~a.cIn;
         cie_pkg::OP_BR_Z:  a.take = a.zIn;
         cie_pkg::OP_BR_NZ: a.take = ~a.zIn;
         cie_pkg::OP_BR_BCLR: begin
            a.cOut = a.opA[a.bitIdx];
            a.updC = 1'b1;
            a.take = ~a.opA[a.bitIdx];
         end
         cie_pkg::OP_BR_BSET: begin
            a.cOut = a.opA[a.bitIdx];
            a.updC = 1'b1;
            a.take = a.opA[a.bitIdx];
         end
         cie_pkg::OP_BSET: a.res = a.opA | (8'h01 << a.bitIdx);
         cie_pkg::OP_BCLR: a.res = a.opA & ~(8'h01 << a.bitIdx);
         default: a.res = a.opA;
      endcase
      a.zOut = (a.res == 8'h00);
   end
endmodule // cie_alu

// ---- rtl/cie_exec.sv ----
// Instruction execution sequencer: operands, flags, pc and cycle timing
// Operation
// - add, and, compare, subtract use accumulator plus data or immediate
// - clear, decrement, increment may target any of the 256 data bytes
// - complement, rotate and shift act on the accumulator only
// - arithmetic takes 4 cycles; inc/dec keep carry; register clear keeps flags
// - conditional branch jumps only when its condition holds, else pc steps past it
// - flag branches 1 byte 2 cycles; bit branches 3 bytes 5 cycles
// - flag branches use 5-bit signed displacement, reach -15 to +16
// - bit branches use 8-bit signed displacement, range -126 to +129
// - bit branch copies tested bit into carry, zero kept
// - bit set and clear reach any bit of any data byte
// - a 3-bit index picks the bit within the byte
// - bit set and clear: 2 bytes, 4 cycles, flags kept
// - control ops 1 byte 2 cycles; only interrupt return changes flags
// - jump and call carry a full 12-bit target
// - with watchdog selected, stop executes as wait
// - jump and call: 2 bytes, 4 cycles, flags kept
`timescale 1ns/1ps
module cie_exec (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // Instruction request
   input  wire logic             start,
   input  cie_pkg::cie_op_t      op,
   input  wire logic [1:0]       arithLen,
   input  wire logic             srcImm,
   input  wire logic             dstAcc,
   input  wire logic [7:0]       immByte,
   input  wire logic [7:0]       dataByte,
   input  wire logic [7:0]       dataAddr,
   input  wire logic [2:0]       bitIdx,
   input  wire logic [4:0]       disp5,
   input  wire logic [7:0]       disp8,
   input  wire logic [11:0]      target,
   // Stack and option inputs
   input  wire logic [11:0]      stackPc,
   input  wire logic             savedZ,
   input  wire logic             savedC,
   input  wire logic             watchdogSel,
   // Status and results
   output logic                  busy,
   output logic                  done,
   output logic [1:0]            instLen,
   output logic [11:0]           pc,
   output logic [7:0]            acc,
   output logic                  zero,
   output logic                  carry,
   // Data space write
   output logic                  memWe,
   output logic [7:0]            memAddr,
   output logic [7:0]            memData,
   // Stack push and power requests
   output logic                  pushEn,
   output logic [11:0]           pushPc,
   output logic                  stopReq,
   output logic                  waitReq
);
   cie_alu_if alu ();

   cie_pkg::cie_state_t st, next_st;
   cie_pkg::cie_op_t    latOp, next_latOp;
   logic [2:0]  cnt, next_cnt;
   logic        latImm, next_latImm, latAcc, next_latAcc;
   logic [7:0]  latImmB, next_latImmB, latData, next_latData, latAddr, next_latAddr;
   logic [2:0]  latBit, next_latBit;
   logic [4:0]  latD5, next_latD5;
   logic [7:0]  latD8, next_latD8;
   logic [11:0] latTgt, next_latTgt;
   logic [1:0]  next_instLen;
   logic        next_busy, next_done, next_zero, next_carry;
   logic [11:0] next_pc, next_pushPc;
   logic [7:0]  next_acc, next_memAddr, next_memData;
   logic        next_memWe, next_pushEn, next_stopReq, next_waitReq;

   // Cycle count of an operation
   function automatic logic [2:0] cycOf(input cie_pkg::cie_op_t o);
      case (o)
         cie_pkg::OP_BR_C, cie_pkg::OP_BR_NC,
         cie_pkg::OP_BR_Z, cie_pkg::OP_BR_NZ:         cycOf = cie_pkg::CYC_BR;
         cie_pkg::OP_BR_BCLR, cie_pkg::OP_BR_BSET:    cycOf = cie_pkg::CYC_BIT_BR;
         cie_pkg::OP_BSET, cie_pkg::OP_BCLR:          cycOf = cie_pkg::CYC_BIT;
         cie_pkg::OP_NOP, cie_pkg::OP_RET, cie_pkg::OP_RETURN_FROM_INTERRUPT,
         cie_pkg::OP_STOP, cie_pkg::OP_WAIT:          cycOf = cie_pkg::CYC_CTRL;
         cie_pkg::OP_JP, cie_pkg::OP_CALL:            cycOf = cie_pkg::CYC_JP;
         default:                                     cycOf = cie_pkg::CYC_ALU;
      endcase
   endfunction

   // Byte length; arithmetic length comes from the addressing-mode decoder
   function automatic logic [1:0] lenOf(input cie_pkg::cie_op_t o, input logic [1:0] al);
      case (o)
         cie_pkg::OP_BR_C, cie_pkg::OP_BR_NC,
         cie_pkg::OP_BR_Z, cie_pkg::OP_BR_NZ:         lenOf = cie_pkg::LEN_BR;
         cie_pkg::OP_BR_BCLR, cie_pkg::OP_BR_BSET:    lenOf = cie_pkg::LEN_BIT_BR;
         cie_pkg::OP_BSET, cie_pkg::OP_BCLR:          lenOf = cie_pkg::LEN_BIT;
         cie_pkg::OP_NOP, cie_pkg::OP_RET, cie_pkg::OP_RETURN_FROM_INTERRUPT,
         cie_pkg::OP_STOP, cie_pkg::OP_WAIT:          lenOf = cie_pkg::LEN_CTRL;
         cie_pkg::OP_JP, cie_pkg::OP_CALL:            lenOf = cie_pkg::LEN_JP;
         default:                                     lenOf = al;
      endcase
   endfunction

   // True for operations whose operand sits in data space rather than the accumulator
   function automatic logic memOperand(input cie_pkg::cie_op_t o, input logic toAcc);
      case (o)
         cie_pkg::OP_CLR, cie_pkg::OP_DEC, cie_pkg::OP_INC: memOperand = ~toAcc;
         cie_pkg::OP_BR_BCLR, cie_pkg::OP_BR_BSET,
         cie_pkg::OP_BSET, cie_pkg::OP_BCLR:                 memOperand = 1'b1;
         default:                                            memOperand = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Operand routing
   // ----------------------------------------------------------------
   // complement, rotate, shift always see the accumulator
   // step and clear ops take the data byte when not on the acc
   assign alu.op     = latOp;
   assign alu.opA    = memOperand(latOp, latAcc) ? latData : acc;
   // second operand: immediate or data byte
   assign alu.opB    = latImm ? latImmB : latData;
   assign alu.bitIdx = latBit;
   assign alu.zIn    = zero;
   assign alu.cIn    = carry;
   assign alu.dstAcc = latAcc;

   cie_alu u_alu (
      .a (alu.alu)
   );

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st      = st;
      next_cnt     = cnt;
      next_latOp   = latOp;
      next_latImm  = latImm;
      next_latAcc  = latAcc;
      next_latImmB = latImmB;
      next_latData = latData;
      next_latAddr = latAddr;
      next_latBit  = latBit;
      next_latD5   = latD5;
      next_latD8   = latD8;
      next_latTgt  = latTgt;
      next_instLen = instLen;
      next_busy    = busy;
      next_pc      = pc;
      next_acc     = acc;
      next_zero    = zero;
      next_carry   = carry;
      next_memAddr = memAddr;
      next_memData = memData;
      next_pushPc  = pushPc;
      // Pulses drop back after one cycle
      next_done    = 1'b0;
      next_memWe   = 1'b0;
      next_pushEn  = 1'b0;
      next_stopReq = 1'b0;
      next_waitReq = 1'b0;
      case (st)
         // Requests are only taken while idle; a start while busy is ignored
         cie_pkg::ST_IDLE: begin
            if (start) begin
               next_st      = cie_pkg::ST_EXEC;
               next_cnt     = cycOf(op) - 3'h1;
               next_latOp   = op;
               next_latImm  = srcImm;
               next_latAcc  = dstAcc;
               next_latImmB = immByte;
               next_latData = dataByte;
               next_latAddr = dataAddr;
               next_latBit  = bitIdx;
               next_latD5   = disp5;
               next_latD8   = disp8;
               next_latTgt  = target;
               next_instLen = lenOf(op, arithLen);
               next_busy    = 1'b1;
            end
         end
         cie_pkg::ST_EXEC: begin
            if (cnt != 3'h0) begin
               next_cnt = cnt - 3'h1;
            end else begin
               // Commit in the last cycle of the instruction
               next_st   = cie_pkg::ST_IDLE;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_pc   = pc + {10'h000, instLen};
               // flags only where the operation updates them
               if (alu.updZ) begin
                  next_zero = alu.zOut;
               end
               if (alu.updC) begin
                  next_carry = alu.cOut;
               end
               case (latOp)
                  cie_pkg::OP_ADD, cie_pkg::OP_AND, cie_pkg::OP_SUB,
                  cie_pkg::OP_COM, cie_pkg::OP_RLC, cie_pkg::OP_SLA: next_acc = alu.res;
                  // Compare leaves the accumulator intact
                  cie_pkg::OP_CP: next_acc = acc;
                  // result to acc or to its data-space byte
                  cie_pkg::OP_CLR, cie_pkg::OP_DEC, cie_pkg::OP_INC,
                  cie_pkg::OP_BSET, cie_pkg::OP_BCLR: begin
                     if (memOperand(latOp, latAcc)) begin
                        next_memWe   = 1'b1;
                        next_memAddr = latAddr;
                        next_memData = alu.res;
                     end else begin
                        next_acc = alu.res;
                     end
                  end
                  // relative reach from a 5-bit displacement
                  cie_pkg::OP_BR_C, cie_pkg::OP_BR_NC,
                  cie_pkg::OP_BR_Z, cie_pkg::OP_BR_NZ: begin
                     if (alu.take) begin
                        next_pc = pc + cie_pkg::REL5_BASE + {{7{latD5[4]}}, latD5};
                     end
                  end
                  // 8-bit displacement from the third byte
                  cie_pkg::OP_BR_BCLR, cie_pkg::OP_BR_BSET: begin
                     if (alu.take) begin
                        next_pc = pc + cie_pkg::REL8_BASE + {{4{latD8[7]}}, latD8};
                     end
                  end
                  cie_pkg::OP_RET: next_pc = stackPc;
                  // only the interrupt return restores flags
                  cie_pkg::OP_RETURN_FROM_INTERRUPT: begin
                     next_pc    = stackPc;
                     next_zero  = savedZ;
                     next_carry = savedC;
                  end
                  cie_pkg::OP_STOP: begin
                     next_stopReq = ~watchdogSel;
                     next_waitReq = watchdogSel;
                  end
                  cie_pkg::OP_WAIT: next_waitReq = 1'b1;
                  cie_pkg::OP_JP: next_pc = latTgt;
                  cie_pkg::OP_CALL: begin
                     next_pushEn = 1'b1;
                     next_pushPc = pc + {10'h000, instLen};
                     next_pc     = latTgt;
                  end
                  default: next_acc = acc;
               endcase
            end
         end
         default: next_st = cie_pkg::ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st      <= cie_pkg::ST_IDLE;
         cnt     <= 3'h0;
         latOp   <= cie_pkg::OP_NOP;
         latImm  <= 1'b0;
         latAcc  <= 1'b0;
         latImmB <= 8'h00;
         latData <= 8'h00;
         latAddr <= 8'h00;
         latBit  <= 3'h0;
         latD5   <= 5'h00;
         latD8   <= 8'h00;
         latTgt  <= 12'h000;
         instLen <= 2'h0;
         busy    <= 1'b0;
         done    <= 1'b0;
         pc      <= cie_pkg::PC_RESET;
         acc     <= cie_pkg::ACC_RESET;
         zero    <= 1'b0;
         carry   <= 1'b0;
         memWe   <= 1'b0;
         memAddr <= 8'h00;
         memData <= 8'h00;
         pushEn  <= 1'b0;
         pushPc  <= 12'h000;
         stopReq <= 1'b0;
         waitReq <= 1'b0;
      end else begin
         st      <= next_st;
         cnt     <= next_cnt;
         latOp   <= next_latOp;
         latImm  <= next_latImm;
         latAcc  <= next_latAcc;
         latImmB <= next_latImmB;
         latData <= next_latData;
         latAddr <= next_latAddr;
         latBit  <= next_latBit;
         latD5   <= next_latD5;
         latD8   <= next_latD8;
         latTgt  <= next_latTgt;
         instLen <= next_instLen;
         busy    <= next_busy;
         done    <= next_done;
         pc      <= next_pc;
         acc     <= next_acc;
         zero    <= next_zero;
         carry   <= next_carry;
         memWe   <= next_memWe;
         memAddr <= next_memAddr;
         memData <= next_memData;
         pushEn  <= next_pushEn;
         pushPc  <= next_pushPc;
         stopReq <= next_stopReq;
         waitReq <= next_waitReq;
      end
   end
endmodule // cie_exec

// ---- tb/cie_mem_model.sv ----
// Data space model: answers reads at once and takes commit writes
`timescale 1ns/1ps
module cie_mem_model (
   // Clock
   input  wire logic       sys_clk,
   // Read side
   input  wire logic [7:0] dataAddr,
   output logic [7:0]      dataByte,
   // Write side
   input  wire logic       memWe,
   input  wire logic [7:0] memAddr,
   input  wire logic [7:0] memData
);
   logic [7:0] ram [256];
   initial begin
      for (int i = 0; i < 256; i++) ram[i] = 8'(i * 37 + 5);
   end
   // Read is combinational: the fetch stage has the byte before the request
   assign dataByte = ram[dataAddr];
   always @(posedge sys_clk) begin
      if (memWe === 1'b1) ram[memAddr] <= memData;
   end
endmodule // cie_mem_model

// ---- tb/cie_exec_sva.sv ----
// Timing, flag and write checks on the execution block ports
`timescale 1ns/1ps
module cie_exec_sva (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // Request
   input wire logic        start,
   input cie_pkg::cie_op_t op,
   input wire logic [7:0]  dataByte,
   input wire logic [7:0]  dataAddr,
   input wire logic [2:0]  bitIdx,
   input wire logic [11:0] target,
   input wire logic        watchdogSel,
   // Results
   input wire logic        busy,
   input wire logic        done,
   input wire logic [11:0] pc,
   input wire logic        zero,
   input wire logic        carry,
   input wire logic        memWe,
   input wire logic [7:0]  memAddr,
   input wire logic [7:0]  memData,
   input wire logic        pushEn,
   input wire logic [11:0] pushPc,
   input wire logic        stopReq,
   input wire logic        waitReq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic       take;
   logic       tbit;
   logic [7:0] mask;
   // Helpers: accepted request, tested bit, bit mask
   assign take = start && !busy;
   assign tbit = dataByte[bitIdx];
   assign mask = 8'h01 << bitIdx;
   AST_ALU_CYC: assert property (take && op <= cie_pkg::OP_SLA |->
      ##1 !done [*4] ##1 done) else $error("arith timing");
   AST_INC_KEEPC: assert property (take && op inside {cie_pkg::OP_INC, cie_pkg::OP_DEC}
      |-> ##5 $stable(carry)) else $error("carry moved");
   AST_BR_CYC: assert property (take && op inside {[cie_pkg::OP_BR_C:cie_pkg::OP_BR_NZ]}
      |-> ##1 !done [*2] ##1 done) else $error("branch timing");
   AST_BITBR_CYC: assert property (take && op inside {cie_pkg::OP_BR_BCLR, cie_pkg::OP_BR_BSET}
      |-> ##1 !done [*5] ##1 done) else $error("bit branch timing");
   AST_BITBR_C: assert property (take && op inside {cie_pkg::OP_BR_BCLR, cie_pkg::OP_BR_BSET}
      |-> ##6 carry == $past(tbit, 6) && $stable(zero)) else $error("bit branch flags");
   AST_BR_SKIP: assert property (take && op == cie_pkg::OP_BR_C && !carry
      |-> ##3 pc == $past(pc, 3) + 12'h001) else $error("untaken branch pc");
   AST_BSET_WR: assert property (take && op == cie_pkg::OP_BSET |-> ##5 memWe &&
      memAddr == $past(dataAddr, 5) && memData == ($past(dataByte, 5) | $past(mask, 5)))
      else $error("bit set write");
   AST_BIT_FLAGS: assert property (take && op inside {cie_pkg::OP_BSET, cie_pkg::OP_BCLR}
      |-> ##1 !done [*4] ##1 done && $stable(zero) && $stable(carry)) else $error("bit op");
   AST_CTRL_CYC: assert property (take && op inside {[cie_pkg::OP_NOP:cie_pkg::OP_WAIT]}
      |-> ##1 !done [*2] ##1 done) else $error("control timing");
   AST_JP_PC: assert property (take && op inside {cie_pkg::OP_JP, cie_pkg::OP_CALL}
      |-> ##1 !done [*4] ##1 done && pc == $past(target, 5)) else $error("jump target");
   AST_CALL_PUSH: assert property (take && op == cie_pkg::OP_CALL
      |-> ##5 pushEn && pushPc == $past(pc, 5) + 12'h002) else $error("call push");
   AST_STOP_WD: assert property (take && op == cie_pkg::OP_STOP && watchdogSel
      |-> ##3 waitReq && !stopReq) else $error("stop with watchdog");
   AST_STOP_PLAIN: assert property (take && op == cie_pkg::OP_STOP && !watchdogSel
      |-> ##3 stopReq && !waitReq) else $error("plain stop");
   // Main scenarios
   cover property (take && op == cie_pkg::OP_CALL);
   cover property (take && op == cie_pkg::OP_BR_BSET ##6 done);
   cover property (done && start ##1 busy);
endmodule // cie_exec_sva
bind cie_exec cie_exec_sva chk (.sys_clk(sys_clk), .nrst(nrst), .start(start), .op(op),
   .dataByte(dataByte), .dataAddr(dataAddr), .bitIdx(bitIdx), .target(target),
   .watchdogSel(watchdogSel), .busy(busy), .done(done), .pc(pc), .zero(zero),
   .carry(carry), .memWe(memWe), .memAddr(memAddr), .memData(memData), .pushEn(pushEn),
   .pushPc(pushPc), .stopReq(stopReq), .waitReq(waitReq));

// ---- tb/cie_exec_test.sv ----
// Self-checking bench for the instruction execution block
`timescale 1ns/1ps
module cie_exec_test;
   // Stimulus
   logic sys_clk = 1'b0, nrst = 1'b0, start = 1'b0, srcImm = 1'b0, dstAcc = 1'b0;
   logic savedZ = 1'b0, savedC = 1'b0, watchdogSel = 1'b0;
   cie_pkg::cie_op_t op = cie_pkg::OP_NOP;
   logic [1:0]  arithLen = 2'h1;
   logic [7:0]  immByte = 8'h00, dataAddr = 8'h00, disp8 = 8'h00;
   logic [4:0]  disp5 = 5'h00;
   logic [2:0]  bitIdx = 3'h0;
   logic [11:0] target = 12'h000, stackPc = 12'h000;
   // Design outputs and partner read data
   logic busy, done, zero, carry, memWe, pushEn, stopReq, waitReq;
   logic [1:0]  instLen;
   logic [11:0] pc, pushPc;
   logic [7:0]  acc, memAddr, memData, dataByte;
   // Expected state and scoreboard
   logic [11:0] ePc;
   logic [7:0]  eAcc;
   logic        eZ, eC;
   logic [23:0] expQ [$];
   integer      seed = 32'h0e85;
   int          num_errors = 0, checked = 0;

   always #5 sys_clk = ~sys_clk;

   cie_exec dut (.sys_clk(sys_clk), .nrst(nrst), .start(start), .op(op), .arithLen(arithLen),
      .srcImm(srcImm), .dstAcc(dstAcc), .immByte(immByte), .dataByte(dataByte),
      .dataAddr(dataAddr), .bitIdx(bitIdx), .disp5(disp5), .disp8(disp8), .target(target),
      .stackPc(stackPc), .savedZ(savedZ), .savedC(savedC), .watchdogSel(watchdogSel),
      .busy(busy), .done(done), .instLen(instLen), .pc(pc), .acc(acc), .zero(zero),
      .carry(carry), .memWe(memWe), .memAddr(memAddr), .memData(memData), .pushEn(pushEn),
      .pushPc(pushPc), .stopReq(stopReq), .waitReq(waitReq));
   cie_mem_model mem (.sys_clk(sys_clk), .dataAddr(dataAddr), .dataByte(dataByte),
      .memWe(memWe), .memAddr(memAddr), .memData(memData));

   task automatic check(input string name, input logic [25:0] seen, input logic [25:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic reset_dut();
      nrst = 1'b0;
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      {ePc, eAcc, eZ, eC} = 22'h0;
      check("reset", {busy, done, instLen, pc, acc, zero, carry}, 26'h0);
   endtask

   // One instruction: random fields, expectation noted, start held into busy to be refused
   task automatic issue(input int k);
      logic [7:0]  b, d, opnd, res;
      logic [11:0] np, s5, s8;
      logic [1:0]  ln;
      logic        zu;
      {immByte, dataAddr, disp8} = 24'($random(seed));
      {target, stackPc, disp5, bitIdx} = $random(seed);
      {srcImm, dstAcc, savedZ, savedC, watchdogSel} = 5'($random(seed));
      arithLen = 2'h1 + 2'($unsigned($random(seed)) % 3);
      op = cie_pkg::cie_op_t'(5'((k < 25) ? k : $unsigned($random(seed)) % 25));
      #1;
      d = dataByte;
      b = srcImm ? immByte : d;
      opnd = dstAcc ? eAcc : d;
      s5 = {{7{disp5[4]}}, disp5};
      s8 = {{4{disp8[7]}}, disp8};
      res = eAcc;
      zu = (op <= cie_pkg::OP_SLA);
      ln = arithLen;
      np = ePc + 12'(arithLen);
      case (op)
         cie_pkg::OP_ADD: {eC, res} = {1'b0, eAcc} + {1'b0, b};
         cie_pkg::OP_AND: {eC, res} = {1'b0, eAcc & b};
         cie_pkg::OP_CP, cie_pkg::OP_SUB: {eC, res} = {eAcc < b, eAcc - b};
         cie_pkg::OP_CLR: if (dstAcc) {eC, res} = 9'h000;
            else zu = 1'b0;
         cie_pkg::OP_DEC: res = opnd - 8'h01;
         cie_pkg::OP_INC: res = opnd + 8'h01;
         cie_pkg::OP_COM: {eC, res} = {eAcc[7], ~eAcc};
         cie_pkg::OP_RLC: {eC, res} = {eAcc, eC};
         cie_pkg::OP_SLA: {eC, res} = {eAcc, 1'b0};
         cie_pkg::OP_BR_C, cie_pkg::OP_BR_NC, cie_pkg::OP_BR_Z, cie_pkg::OP_BR_NZ:
            {ln, np} = {2'h1, ePc + 12'h001 + (((op[1] ? eC : eZ) ^ op[0]) ? s5 : 12'h000)};
         cie_pkg::OP_BR_BCLR, cie_pkg::OP_BR_BSET: {ln, np, eC} =
            {2'h3, ePc + ((d[bitIdx] == op[0]) ? 12'h002 + s8 : 12'h003), d[bitIdx]};
         cie_pkg::OP_BSET, cie_pkg::OP_BCLR: {ln, np} = {2'h2, ePc + 12'h002};
         cie_pkg::OP_RET: {ln, np} = {2'h1, stackPc};
         cie_pkg::OP_RETURN_FROM_INTERRUPT: {ln, np, eZ, eC} = {2'h1, stackPc, savedZ, savedC};
         cie_pkg::OP_JP, cie_pkg::OP_CALL: {ln, np} = {2'h2, target};
         default: {ln, np} = {2'h1, ePc + 12'h001};
      endcase
      if (zu) eZ = (res == 8'h00);
      if (zu && op != cie_pkg::OP_CP && (dstAcc || op < cie_pkg::OP_CLR || op > cie_pkg::OP_INC))
         eAcc = res;
      expQ.push_back({ln, np, eAcc, eZ, eC});
      ePc = np;
      start = 1'b1;
      @(posedge sys_clk);
      @(posedge sys_clk);
      @(negedge sys_clk);
      start = 1'b0;
      repeat (8) if (done !== 1'b1) @(negedge sys_clk);
      check("done", {25'h0, done}, 26'h1);
   endtask

   // Result monitor: each commit takes the oldest note
   always @(negedge sys_clk) begin
      if (done === 1'b1) check("commit", {2'h0, instLen, pc, acc, zero, carry},
         {2'h0, expQ.pop_front()});
   end

   initial begin
      reset_dut();
      for (int k = 0; k < 300; k++) begin
         if (k == 150) reset_dut();
         issue(k);
      end
      repeat (4) @(negedge sys_clk);
      check("pending", 26'(expQ.size()), 26'h0);
      test_done();
   end

   // Watchdog: 300 instructions of at most 8 cycles fit well inside this span
   initial begin
      #100000;
      num_errors++;
      test_done();
   end
endmodule // cie_exec_test
